// >>> rtl/cscs_iclk_div.sv
// instruction clock enable: divides the system clock rate by two
// assumes one clock domain and a synchronised reset
`timescale 1ns/10ps
`include "cscs_cfg.svh"
module cscs_iclk_div (
    input wire logic sys_clk,
    input wire logic rst_n,
    output logic iclk_en,
    output logic iclk_lvl
);
    typedef struct packed {
        logic [$clog2(`CSCS_ICLK_DIV)-1:0] cnt;
        logic lvl;
        logic en;
    } cscs_div_t;
    cscs_div_t st_ff;
    cscs_div_t nxt_st;
    localparam int DIV_W = $clog2(`CSCS_ICLK_DIV);
    localparam logic [DIV_W-1:0] LAST = DIV_W'(`CSCS_ICLK_DIV - 1);
    always_comb
    begin
        nxt_st = st_ff;
        nxt_st.en = (st_ff.cnt == LAST);
        if (st_ff.cnt == LAST)
        begin
            nxt_st.cnt = '0;
        end
        else
        begin
            nxt_st.cnt = st_ff.cnt + 1'b1;
        end
        nxt_st.lvl = (nxt_st.cnt == '0);
    end
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_ff <= '0;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end
    assign iclk_en = st_ff.en;
    assign iclk_lvl = st_ff.lvl;
    iclk_period_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        iclk_en |=> !iclk_en ##1 iclk_en) else $error("instruction clock not half rate");
endmodule : cscs_iclk_div

// >>> rtl/cscs_top.sv
// power-on clock source decoder for the two oscillator configuration words
// assumes the words are static from program memory; source ready, failure
// detect and remap request come from the oscillator and pin-select logic
`timescale 1ns/10ps
`include "cscs_cfg.svh"
module cscs_top (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic [15:0] initial_source_config_word,
    input wire logic [15:0] oscillator_mode_config_word,
    input wire logic src_ready,
    input wire logic clk_fail_det,
    input wire logic clk_fail_clr,
    input wire logic remap_req,
    input wire logic sw_req,
    input wire logic [2:0] sw_new_src,
    input wire logic gpio_out,
    input wire logic gpio_oe,
    input wire logic osc_out_pin_i,
    output logic [2:0] current_source,
    output logic [2:0] new_source,
    output logic [1:0] primary_osc_mode,
    output logic pri_osc_en,
    output logic switch_en,
    output logic failsafe_clock_monitor,
    output logic clock_fail_flag,
    output logic remap_allowed,
    output logic remap_ack,
    output logic cfg_valid,
    output logic osc_out_pin_o,
    output logic osc_out_pin_oe,
    output logic gpio_in
);
    typedef struct packed {
        cscs_pkg::cscs_state_t state;
        logic [2:0] cfg_src;
        logic [1:0] pmode;
        logic pin_func;
        logic two_speed;
        logic [1:0] swmon;
        logic one_shot;
        logic [2:0] cur;
        logic [2:0] nxt;
        logic fail;
        logic remap_done;
        logic remap_ok;
        logic ack;
        logic valid;
        logic pri_en;
        logic sw_en;
        logic failsafe_clock_monitor_en;
        logic pin_o;
        logic pin_oe;
        logic gin;
    } cscs_st_t;
    cscs_st_t st_ff;
    cscs_st_t nxt_st;
    logic [1:0] rst_sync_ff;
    logic rst_n;
    logic iclk_lvl;
    // reset release through two flops
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            rst_sync_ff <= 2'h0;
        end
        else
        begin
            rst_sync_ff <= {rst_sync_ff[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_ff[1];
    cscs_iclk_div u_div (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .iclk_en(),
        .iclk_lvl(iclk_lvl)
    );
    // primary mode only matters for the two primary sources
    function automatic logic uses_pri(input logic [2:0] src);
        uses_pri = (src == cscs_pkg::CSCS_SRC_PRI) || (src == cscs_pkg::CSCS_SRC_PRI_PLL);
    endfunction : uses_pri
    function automatic logic is_crystal(input logic [2:0] src, input logic [1:0] pm);
        is_crystal = uses_pri(src) && ((pm == cscs_pkg::CSCS_PM_XT_MED) ||
            (pm == cscs_pkg::CSCS_PM_XT_HIGH));
    endfunction : is_crystal
    always_comb
    begin
        nxt_st = st_ff;
        nxt_st.ack = 1'b0;
        unique case (st_ff.state)
            cscs_pkg::CSCS_ST_LATCH:
            begin
                // words only read, never written here
                nxt_st.cfg_src = initial_source_config_word[`CSCS_SRC_LSB +: 3];
                nxt_st.two_speed = initial_source_config_word[`CSCS_TWO_SPEED_BIT];
                nxt_st.pmode = oscillator_mode_config_word[`CSCS_PMODE_LSB +: 2];
                nxt_st.pin_func = oscillator_mode_config_word[`CSCS_PINFUNC_BIT];
                nxt_st.swmon = oscillator_mode_config_word[`CSCS_SWMON_LSB +: 2];
                nxt_st.one_shot = oscillator_mode_config_word[`CSCS_REMAP_BIT];
                // power-on source from field, erased gives 111
                nxt_st.nxt = initial_source_config_word[`CSCS_SRC_LSB +: 3];
                // two-speed start runs on fast rc first
                if (initial_source_config_word[`CSCS_TWO_SPEED_BIT])
                begin
                    nxt_st.cur = cscs_pkg::CSCS_SRC_FRC;
                    nxt_st.state = cscs_pkg::CSCS_ST_WAIT;
                end
                else
                begin
                    nxt_st.cur = initial_source_config_word[`CSCS_SRC_LSB +: 3];
                    nxt_st.state = cscs_pkg::CSCS_ST_RUN;
                end
                nxt_st.valid = 1'b1;
                nxt_st.remap_ok = 1'b1;
                // enables decoded once so the outputs come from flops
                nxt_st.pri_en = uses_pri(nxt_st.cfg_src) && (nxt_st.pmode != cscs_pkg::CSCS_PM_OFF);
                nxt_st.sw_en = !nxt_st.swmon[1];
                nxt_st.failsafe_clock_monitor_en = (nxt_st.swmon == 2'h0);
            end
            cscs_pkg::CSCS_ST_WAIT:
            begin
                // hand over when configured source ready
                if (src_ready)
                begin
                    nxt_st.cur = st_ff.cfg_src;
                    nxt_st.state = cscs_pkg::CSCS_ST_RUN;
                end
            end
            cscs_pkg::CSCS_ST_RUN:
            begin
                // later changes only through enabled switching
                if (sw_req && st_ff.sw_en)
                begin
                    nxt_st.nxt = sw_new_src;
                    nxt_st.cur = sw_new_src;
                end
            end
            default:
            begin
                nxt_st.state = cscs_pkg::CSCS_ST_LATCH;
            end
        endcase
        // fail flag sticky, set wins over clear
        if (clk_fail_clr)
        begin
            nxt_st.fail = 1'b0;
        end
        if (clk_fail_det && st_ff.failsafe_clock_monitor_en)
        begin
            nxt_st.fail = 1'b1;
        end
        if (remap_req && st_ff.remap_ok)
        begin
            nxt_st.ack = 1'b1;
            nxt_st.remap_done = 1'b1;
            nxt_st.remap_ok = !st_ff.one_shot;
        end
        // pin owned by crystal, else clock out or gpio
        if (!st_ff.valid || is_crystal(st_ff.cfg_src, st_ff.pmode))
        begin
            nxt_st.pin_o = 1'b0;
            nxt_st.pin_oe = 1'b0;
        end
        else if (st_ff.pin_func)
        begin
            nxt_st.pin_o = iclk_lvl;
            nxt_st.pin_oe = 1'b1;
        end
        else
        begin
            nxt_st.pin_o = gpio_out;
            nxt_st.pin_oe = gpio_oe;
        end
        nxt_st.gin = osc_out_pin_i;
    end
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_ff <= '0;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end
    // outputs straight from the state flops
    assign current_source = st_ff.cur;
    assign new_source = st_ff.nxt;
    assign primary_osc_mode = st_ff.pmode;
    assign pri_osc_en = st_ff.pri_en;
    assign switch_en = st_ff.sw_en;
    assign failsafe_clock_monitor = st_ff.failsafe_clock_monitor_en;
    assign clock_fail_flag = st_ff.fail;
    assign remap_allowed = st_ff.remap_ok;
    assign remap_ack = st_ff.ack;
    assign cfg_valid = st_ff.valid;
    assign osc_out_pin_o = st_ff.pin_o;
    assign osc_out_pin_oe = st_ff.pin_oe;
    assign gpio_in = st_ff.gin;
    // reserved bits are the programmer's duty; nothing here depends on them
    // power-on source seeded from the word
    por_source_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (st_ff.state == cscs_pkg::CSCS_ST_LATCH && !initial_source_config_word[7]) |=>
        current_source == $past(initial_source_config_word[2:0])) else $error("power-on source wrong");
    new_seed_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        st_ff.state == cscs_pkg::CSCS_ST_LATCH |=>
        new_source == $past(initial_source_config_word[2:0])) else $error("new source not seeded");
    two_speed_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (st_ff.state == cscs_pkg::CSCS_ST_LATCH && initial_source_config_word[7]) |=>
        current_source == 3'h0) else $error("two-speed start not on fast rc");
    cfg_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $past(cfg_valid) |-> $stable(primary_osc_mode) && $stable(st_ff.cfg_src))
        else $error("latched configuration changed");
    switch_block_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (st_ff.state == cscs_pkg::CSCS_ST_RUN && st_ff.swmon[1]) |=> $stable(current_source))
        else $error("source changed with switching disabled");
    fail_set_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (clk_fail_det && failsafe_clock_monitor) |=> clock_fail_flag)
        else $error("clock fail not flagged");
    fail_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (clock_fail_flag && !clk_fail_clr) |=> clock_fail_flag)
        else $error("clock fail flag dropped");
    one_shot_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (remap_ack && st_ff.one_shot) |-> !remap_allowed)
        else $error("second remap allowed");
    crystal_pin_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $past(cfg_valid) && is_crystal(st_ff.cfg_src, st_ff.pmode) |-> !osc_out_pin_oe)
        else $error("pin driven in crystal mode");
endmodule : cscs_top

// >>> shared/cscs_cfg.svh
// constants for the clock source configuration decoder
// assumes configuration words arrive as static 16-bit values from program memory
// Functional notes
// - the instruction clock is the system clock divided by two.
// - at power-on reset the system clock source comes from the 3-bit initial source field, later only switching changes it.
// - initial source codes 000..111 select fast rc, fast rc with pll, primary, primary with pll, secondary, low power rc, fast rc div16, fast rc div n.
// - an erased configuration word selects fast rc div n, code 111.
// - primary mode 11 disables the primary oscillator, 10 crystal high, 01 crystal medium, 00 external clock.
// - the primary mode field matters only for initial source 010 or 011.
// - with the pin function bit set the instruction clock drives the oscillator output pin, else the pin is general i/o.
// - the pin function bit is ignored while a crystal mode owns the oscillator output pin.
// - with two-speed start-up set the device starts on fast rc and switches to the configured source once it is ready.
// - switch/monitor mode 1x disables both, 01 enables switching only, 00 enables switching and the fail-safe monitor.
// - with the one-shot remap bit set the pin mapping may be reconfigured only once.
// - both words live in program memory and are read-only after programming.
// - after power-on reset the current and new source fields start from the initial source setting; with two-speed start-up current starts at fast rc.
// - a detected clock failure sets the clock fail flag, which stays set until software clears it.
`ifndef CSCS_CFG_SVH
`define CSCS_CFG_SVH
`define CSCS_SRC_LSB 0
`define CSCS_TWO_SPEED_BIT 7
`define CSCS_PMODE_LSB 0
`define CSCS_PINFUNC_BIT 2
`define CSCS_REMAP_BIT 5
`define CSCS_SWMON_LSB 6
`define CSCS_ERASED_WORD 16'hFFFF
`define CSCS_ICLK_DIV 2
`endif

// >>> shared/cscs_pkg.sv
// types for the clock source configuration decoder
// assumes no other package is needed
package cscs_pkg;
    typedef enum logic [2:0] {
        CSCS_SRC_FRC = 3'h0,
        CSCS_SRC_FRC_PLL = 3'h1,
        CSCS_SRC_PRI = 3'h2,
        CSCS_SRC_PRI_PLL = 3'h3,
        CSCS_SRC_SEC = 3'h4,
        CSCS_SRC_LOW_POWER_RC_OSC = 3'h5,
        CSCS_SRC_FRC_DIV16 = 3'h6,
        CSCS_SRC_FRC_DIVN = 3'h7
    } cscs_src_t;
    typedef enum logic [1:0] {
        CSCS_PM_EXT = 2'h0,
        CSCS_PM_XT_MED = 2'h1,
        CSCS_PM_XT_HIGH = 2'h2,
        CSCS_PM_OFF = 2'h3
    } cscs_pmode_t;
    typedef enum logic [1:0] {
        CSCS_ST_LATCH = 2'h0,
        CSCS_ST_WAIT = 2'h1,
        CSCS_ST_RUN = 2'h2
    } cscs_state_t;
endpackage : cscs_pkg

// >>> sim/tb_cscs_top.sv
// self-checking bench for the power-on clock source decoder
// assumes the bench alone drives every input of cscs_top, words included
`timescale 1ns/10ps
module tb_cscs_top;
    logic sys_clk = 1'b0;
    logic rstn = 1'b0;
    logic [15:0] isw = 16'hFFFF;
    logic [15:0] omw = 16'hFFFF;
    logic src_ready = 1'b0;
    logic clk_fail_det = 1'b0;
    logic clk_fail_clr = 1'b0;
    logic remap_req = 1'b0;
    logic sw_req = 1'b0;
    logic [2:0] sw_new_src = 3'h0;
    logic gpio_out = 1'b0;
    logic gpio_oe = 1'b0;
    logic osc_out_pin_i = 1'b0;
    logic [2:0] current_source;
    logic [2:0] new_source;
    logic [1:0] primary_osc_mode;
    logic pri_osc_en;
    logic switch_en;
    logic failsafe_clock_monitor;
    logic clock_fail_flag;
    logic remap_allowed;
    logic remap_ack;
    logic cfg_valid;
    logic osc_out_pin_o;
    logic osc_out_pin_oe;
    logic gpio_in;
    int failures = 0;
    int tests_run = 0;
    logic lvl;

    always #5 sys_clk = ~sys_clk;

    cscs_top dut (.sys_clk(sys_clk), .rstn(rstn), .initial_source_config_word(isw),
        .oscillator_mode_config_word(omw), .src_ready(src_ready),
        .clk_fail_det(clk_fail_det), .clk_fail_clr(clk_fail_clr), .remap_req(remap_req),
        .sw_req(sw_req), .sw_new_src(sw_new_src), .gpio_out(gpio_out), .gpio_oe(gpio_oe),
        .osc_out_pin_i(osc_out_pin_i), .current_source(current_source),
        .new_source(new_source), .primary_osc_mode(primary_osc_mode),
        .pri_osc_en(pri_osc_en), .switch_en(switch_en),
        .failsafe_clock_monitor(failsafe_clock_monitor), .clock_fail_flag(clock_fail_flag),
        .remap_allowed(remap_allowed), .remap_ack(remap_ack), .cfg_valid(cfg_valid),
        .osc_out_pin_o(osc_out_pin_o), .osc_out_pin_oe(osc_out_pin_oe), .gpio_in(gpio_in));

    // ****************************************
    // helpers
    // ****************************************
    // reserved bits always programmed as ones
    // reserved bits one
    function automatic logic [15:0] src_w(input logic [2:0] c, input logic ts);
        src_w = {8'hFF, ts, 4'hF, c};
    endfunction : src_w

    function automatic logic [15:0] mode_w(input logic [1:0] sm, input logic os,
                                           input logic pf, input logic [1:0] pm);
        mode_w = {8'hFF, sm, os, 2'h3, pf, pm};
    endfunction : mode_w

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            failures++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic wait_valid();
        for (int n = 0; n < 10 && cfg_valid !== 1'b1; n++)
        begin
            @(posedge sys_clk);
            #1;
        end
        chk(cfg_valid, 8'h01);
        // pin drive settles one cycle after the latch
        @(posedge sys_clk);
        #1;
    endtask : wait_valid

    task automatic do_reset(input logic [15:0] s, input logic [15:0] m);
        @(posedge sys_clk);
        rstn <= 1'b0;
        isw <= s;
        omw <= m;
        #1;
        chk(cfg_valid, 8'h00);
        repeat (2) @(posedge sys_clk);
        rstn <= 1'b1;
        wait_valid();
    endtask : do_reset

    // 0 fail detect, 1 fail clear, 2 remap, 3 switch
    task automatic pulse(input int k);
        @(posedge sys_clk);
        case (k)
            0: clk_fail_det <= 1'b1;
            1: clk_fail_clr <= 1'b1;
            2: remap_req <= 1'b1;
            default: sw_req <= 1'b1;
        endcase
        @(posedge sys_clk);
        {clk_fail_det, clk_fail_clr, remap_req, sw_req} <= 4'h0;
        #1;
    endtask : pulse

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : tally_and_finish

    // ****************************************
    // tests
    // ****************************************
    initial
    begin
        repeat (6) @(posedge sys_clk);
        rstn <= 1'b1;
        wait_valid();
        chk(new_source, cscs_pkg::CSCS_SRC_FRC_DIVN);
        chk(current_source, cscs_pkg::CSCS_SRC_FRC);
        chk(switch_en, 8'h00);
        chk(failsafe_clock_monitor, 8'h00);
        chk(osc_out_pin_oe, 8'h01);
        @(posedge sys_clk);
        isw <= src_w(3'h0, 1'b0);
        omw <= mode_w(2'h0, 1'b0, 1'b0, 2'h1);
        repeat (3) @(posedge sys_clk);
        #1;
        chk(new_source, cscs_pkg::CSCS_SRC_FRC_DIVN);
        chk(switch_en, 8'h00);
        for (int c = 0; c < 8; c++)
        begin
            do_reset(src_w(c[2:0], 1'b0), mode_w(2'h1, 1'b0, 1'b1, 2'h1));
            chk(current_source, c[7:0]);
            chk(new_source, c[7:0]);
            chk(osc_out_pin_oe, (c == 2 || c == 3) ? 8'h00 : 8'h01);
        end
        for (int m = 0; m < 4; m++)
        begin
            do_reset(src_w(3'h2, 1'b0), mode_w(2'h2, 1'b0, 1'b1, m[1:0]));
            chk(primary_osc_mode, m[7:0]);
            chk(pri_osc_en, (m == 3) ? 8'h00 : 8'h01);
            chk(osc_out_pin_oe, (m == 1 || m == 2) ? 8'h00 : 8'h01);
        end
        chk(switch_en, 8'h00);
        sw_new_src <= 3'h4;
        pulse(3);
        chk(current_source, cscs_pkg::CSCS_SRC_PRI);
        do_reset(src_w(3'h0, 1'b0), mode_w(2'h0, 1'b1, 1'b1, 2'h0));
        chk(failsafe_clock_monitor, 8'h01);
        lvl = osc_out_pin_o;
        @(posedge sys_clk);
        #1;
        chk(osc_out_pin_o, {7'h00, ~lvl});
        @(posedge sys_clk);
        #1;
        chk(osc_out_pin_o, {7'h00, lvl});
        pulse(0);
        chk(clock_fail_flag, 8'h01);
        @(posedge sys_clk);
        #1;
        chk(clock_fail_flag, 8'h01);
        // detect and clear together: the set must win
        @(posedge sys_clk);
        clk_fail_det <= 1'b1;
        clk_fail_clr <= 1'b1;
        @(posedge sys_clk);
        {clk_fail_det, clk_fail_clr} <= 2'h0;
        #1;
        chk(clock_fail_flag, 8'h01);
        pulse(1);
        @(posedge sys_clk);
        #1;
        chk(clock_fail_flag, 8'h00);
        sw_new_src <= 3'h5;
        pulse(3);
        chk(current_source, cscs_pkg::CSCS_SRC_LOW_POWER_RC_OSC);
        pulse(2);
        chk(remap_ack, 8'h01);
        pulse(2);
        chk(remap_ack, 8'h00);
        chk(remap_allowed, 8'h00);
        do_reset(src_w(3'h0, 1'b0), mode_w(2'h1, 1'b0, 1'b0, 2'h0));
        chk(switch_en, 8'h01);
        chk(failsafe_clock_monitor, 8'h00);
        pulse(0);
        chk(clock_fail_flag, 8'h00);
        pulse(2);
        chk(remap_ack, 8'h01);
        pulse(2);
        chk(remap_ack, 8'h01);
        @(posedge sys_clk);
        gpio_oe <= 1'b1;
        gpio_out <= 1'b1;
        osc_out_pin_i <= 1'b1;
        repeat (2) @(posedge sys_clk);
        #1;
        chk({osc_out_pin_oe, osc_out_pin_o, gpio_in}, 8'h07);
        do_reset(src_w(3'h2, 1'b1), mode_w(2'h2, 1'b0, 1'b1, 2'h0));
        chk(current_source, cscs_pkg::CSCS_SRC_FRC);
        repeat (3) @(posedge sys_clk);
        src_ready <= 1'b1;
        #1;
        chk(current_source, cscs_pkg::CSCS_SRC_FRC);
        for (int n = 0; n < 3 && current_source !== 3'h2; n++)
        begin
            @(posedge sys_clk);
            #1;
        end
        chk(current_source, cscs_pkg::CSCS_SRC_PRI);
        tally_and_finish();
    end

    // the whole run is about 150 cycles
    initial
    begin
        #20000;
        failures++;
        tally_and_finish();
    end
endmodule : tb_cscs_top
